/* psc_conversion_flag_timer.sv */
// conversion timer: busy while the selected ratio's time runs
`default_nettype none
module psc_conversion_flag_timer
    import psc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = 1024
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    input  wire logic                 abort,
    input  wire logic [PSC_SEL_W-1:0] ratio_sel,
    output logic                      busy,
    output logic                      done
);
    logic [PSC_CONVERSION_FLAG_CNT_W-1:0] cnt_r;
    logic [PSC_CONVERSION_FLAG_CNT_W-1:0] cnt_nxt;
    logic [PSC_CONVERSION_FLAG_CNT_W-1:0] load_val;
    logic                      expire;

    // each ratio step doubles the conversion time
    assign load_val = PSC_CONVERSION_FLAG_CNT_W'((BASE_CYCLES << ratio_sel) - 1);
    assign expire   = busy && (cnt_r == '0);
    assign cnt_nxt  = start ? load_val : (busy && !expire) ? cnt_r - 1'b1 : cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (abort) begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy  <= start || (busy && !expire);
            done  <= expire && !start;
        end
    end
endmodule
`default_nettype wire

/* psc_host_model.sv */
// i2c controller model for the sensor's bus pins
`default_nettype none
module psc_host_model #(
    parameter int H = 40
) (
    input  wire logic ref_clk,
    input  wire logic sda_wire,
    output var logic  scl,
    output var logic  sda_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // scl stands high between frames, sda released to the pull-up
    initial begin
        scl = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic start();
        tick(H);
        sda_out <= 1'b0;
        tick(H);
        scl <= 1'b0;
    endtask
    task automatic stop();
        sda_out <= 1'b0;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_out <= 1'b1;
        tick(H);
    endtask
    // short hold after the fall so sda never moves with scl high
    task automatic bit_io(input logic b, output logic s);
        tick(4);
        sda_out <= b;
        tick(H);
        scl <= 1'b1;
        tick(H / 2);
        s = sda_wire;
        tick(H / 2);
        scl <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

/* psc_pkg.sv */
// shared constants and types for the pressure sensor command block
`default_nettype none
package psc_pkg;
    localparam logic [6:0] PSC_TARGET_ADDR  = 7'h76;
    localparam logic [2:0] PSC_LAST_BIT     = 3'h7;
    localparam logic [2:0] PSC_BIT_ZERO     = 3'h0;
    localparam logic [2:0] PSC_BIT_ONE      = 3'h1;
    localparam logic [7:0] PSC_CMD_RESET    = 8'h1E;
    localparam logic [7:0] PSC_CMD_ADC_READ = 8'h00;
    localparam logic [7:0] PSC_CONVERSION_FLAG_MASK    = 8'hE1;
    localparam logic [7:0] PSC_CONVERSION_FLAG_CODE    = 8'h40;
    localparam logic [7:0] PSC_CAL_MASK     = 8'hF1;
    localparam logic [7:0] PSC_CAL_CODE     = 8'hA0;
    localparam logic [7:0] PSC_PAD_BYTE     = 8'h00;
    localparam logic [2:0] PSC_RATIO_MAX    = 3'h5;
    localparam logic       PSC_SDA_LOW      = 1'b0;
    localparam int         PSC_TYPE_BIT     = 4;
    localparam int         PSC_SEL_LSB      = 1;
    localparam int         PSC_SEL_W        = 3;
    localparam int         PSC_CAL_WORDS    = 7;
    localparam int         PSC_CAL_SLOTS    = 8;
    localparam int         PSC_CAL_WORD_W   = 16;
    localparam int         PSC_CAL_BITS     = 112;
    localparam int         PSC_RESULT_W     = 24;
    localparam int         PSC_CONVERSION_FLAG_CNT_W   = 20;

    typedef enum logic [6:0] {
        PSC_LK_IDLE  = 7'h01,
        PSC_LK_ADDR  = 7'h02,
        PSC_LK_AACK  = 7'h04,
        PSC_LK_WRITE = 7'h08,
        PSC_LK_WACK  = 7'h10,
        PSC_LK_READ  = 7'h20,
        PSC_LK_RACK  = 7'h40
    } psc_link_state_type;
endpackage
`default_nettype wire

/* psc_sensor_cmd.sv */
// sensor-side i2c target, command decoder and transaction sequencer
// Contract
// - answer only target address 1110110, r/w bit
// - one command byte after address, acknowledged
// - reset command reloads calibration, clears state
// - reset command acts at any time
// - pressure conversion codes select six ratios
// - temperature codes differ only in type bit
// - busy until conversion done, then result valid
// - result read returns 24 bits, msb first
// - acknowledge pause after every eight bits
// - no fresh conversion means zero result
// - read during conversion gives zero, corrupts result
// - calibration read codes carry index bits 3:1
// - calibration store holds seven 16-bit words
// - calibration word returned in separate read, msb first
`default_nettype none
module psc_sensor_cmd
    import psc_pkg::*;
#(
    parameter int unsigned CONVERSION_FLAG_BASE_CYCLES = 1024
) (
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    input  wire logic                    link_clk,
    input  wire logic                    scl_line,
    input  wire logic                    sda_sense,
    output logic                         sda_drive,
    output logic                         sda_drive_en,
    input  wire logic [PSC_CAL_BITS-1:0] calibration_store,
    input  wire logic [PSC_RESULT_W-1:0] pressure_sample,
    input  wire logic [PSC_RESULT_W-1:0] temperature_sample,
    output logic                         conversion_flag,
    output logic                         result_ready
);
    // link domain
    logic                    link_rstn;
    logic                    scl_s;
    logic                    sda_s;
    logic                    scl_d_r;
    logic                    sda_d_r;
    logic                    word_tgl_s;
    logic                    word_tgl_d_r;
    logic [PSC_RESULT_W-1:0] word_hold_r;
    psc_link_state_type      state_r;
    psc_link_state_type      state_nxt;
    logic [2:0]              bit_cnt_r;
    logic [2:0]              bit_cnt_nxt;
    logic [7:0]              shift_r;
    logic [7:0]              shift_nxt;
    logic                    full_r;
    logic                    full_nxt;
    logic                    oe_nxt;
    logic                    rw_r;
    logic                    rw_nxt;
    logic                    nack_r;
    logic                    nack_nxt;
    logic [PSC_RESULT_W-1:0] tx_r;
    logic [PSC_RESULT_W-1:0] tx_nxt;
    logic [7:0]              cmd_byte_r;
    logic [7:0]              cmd_byte_nxt;
    logic                    cmd_tgl_r;
    logic                    cmd_tgl_nxt;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_evt;
    logic                    stop_evt;
    logic                    addr_hit;
    logic                    word_evt;

    // reference domain
    logic                      cmd_tgl_s;
    logic                      cmd_tgl_d_r;
    logic                      cmd_evt;
    logic                      is_reset;
    logic                      is_conversion_flag;
    logic                      is_adc;
    logic                      is_cal;
    logic [PSC_SEL_W-1:0]      sel;
    logic                      conversion_flag_start;
    logic                      conversion_flag_done;
    logic                      type_r;
    logic [PSC_CAL_BITS-1:0]   cal_hold_r;
    logic [PSC_CAL_WORD_W-1:0] cal_slot [PSC_CAL_SLOTS];
    logic [PSC_CAL_WORD_W-1:0] cal_word;
    logic [PSC_RESULT_W-1:0]   result_r;
    logic [PSC_RESULT_W-1:0]   result_nxt;
    logic [PSC_RESULT_W-1:0]   sample_pick;
    logic                      result_valid_r;
    logic                      valid_nxt;
    logic                      corrupt_r;
    logic                      corrupt_nxt;
    logic [PSC_RESULT_W-1:0]   word_r;
    logic [PSC_RESULT_W-1:0]   word_pick;
    logic                      word_load;
    logic                      word_tgl_r;

    assign sda_drive = PSC_SDA_LOW;

    psc_sync2 u_link_rst (
        .clk   (link_clk),
        .rst_n (resetn),
        .din   (1'b1),
        .dout  (link_rstn)
    );
    psc_sync2 u_scl_sync (
        .clk   (link_clk),
        .rst_n (link_rstn),
        .din   (scl_line),
        .dout  (scl_s)
    );
    psc_sync2 u_sda_sync (
        .clk   (link_clk),
        .rst_n (link_rstn),
        .din   (sda_sense),
        .dout  (sda_s)
    );
    psc_sync2 u_word_sync (
        .clk   (link_clk),
        .rst_n (link_rstn),
        .din   (word_tgl_r),
        .dout  (word_tgl_s)
    );
    psc_sync2 u_cmd_sync (
        .clk   (ref_clk),
        .rst_n (resetn),
        .din   (cmd_tgl_r),
        .dout  (cmd_tgl_s)
    );

    assign scl_rise  = scl_s && !scl_d_r;
    assign scl_fall  = !scl_s && scl_d_r;
    assign start_evt = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_evt  = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign addr_hit  = (shift_r[7:1] == PSC_TARGET_ADDR);
    assign word_evt  = word_tgl_s ^ word_tgl_d_r;

    always_comb begin
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        shift_nxt    = shift_r;
        full_nxt     = full_r;
        oe_nxt       = sda_drive_en;
        rw_nxt       = rw_r;
        nack_nxt     = nack_r;
        tx_nxt       = tx_r;
        cmd_byte_nxt = cmd_byte_r;
        cmd_tgl_nxt  = cmd_tgl_r;
        if (stop_evt) begin
            // letting go of sda here frees a bus stuck in an ack
            state_nxt = PSC_LK_IDLE;
            oe_nxt    = 1'b0;
        end else if (start_evt) begin
            state_nxt   = PSC_LK_ADDR;
            oe_nxt      = 1'b0;
            bit_cnt_nxt = PSC_BIT_ZERO;
            full_nxt    = 1'b0;
        end else if (scl_rise) begin
            if (state_r == PSC_LK_ADDR || state_r == PSC_LK_WRITE) begin
                shift_nxt   = {shift_r[6:0], sda_s};
                bit_cnt_nxt = bit_cnt_r + PSC_BIT_ONE;
                full_nxt    = (bit_cnt_r == PSC_LAST_BIT);
            end else if (state_r == PSC_LK_RACK) begin
                nack_nxt = sda_s;
            end
        end else if (scl_fall) begin
            unique case (state_r)
                PSC_LK_IDLE: begin
                    oe_nxt = 1'b0;
                end
                PSC_LK_ADDR: begin
                    if (full_r) begin
                        full_nxt  = 1'b0;
                        state_nxt = addr_hit ? PSC_LK_AACK : PSC_LK_IDLE;
                        oe_nxt    = addr_hit;
                        rw_nxt    = shift_r[0];
                        tx_nxt    = word_hold_r;
                    end
                end
                PSC_LK_AACK: begin
                    bit_cnt_nxt = PSC_BIT_ZERO;
                    state_nxt   = rw_r ? PSC_LK_READ : PSC_LK_WRITE;
                    oe_nxt      = rw_r && !tx_r[PSC_RESULT_W-1];
                end
                PSC_LK_WRITE: begin
                    if (full_r) begin
                        full_nxt     = 1'b0;
                        state_nxt    = PSC_LK_WACK;
                        oe_nxt       = 1'b1;
                        cmd_byte_nxt = shift_r;
                        cmd_tgl_nxt  = !cmd_tgl_r;
                    end
                end
                PSC_LK_WACK: begin
                    state_nxt = PSC_LK_WRITE;
                    oe_nxt    = 1'b0;
                end
                PSC_LK_READ: begin
                    tx_nxt = {tx_r[PSC_RESULT_W-2:0], 1'b0};
                    if (bit_cnt_r == PSC_LAST_BIT) begin
                        state_nxt   = PSC_LK_RACK;
                        oe_nxt      = 1'b0;
                        bit_cnt_nxt = PSC_BIT_ZERO;
                    end else begin
                        oe_nxt      = !tx_r[PSC_RESULT_W-2];
                        bit_cnt_nxt = bit_cnt_r + PSC_BIT_ONE;
                    end
                end
                PSC_LK_RACK: begin
                    // a nack ends the read; the host then sends stop
                    state_nxt = nack_r ? PSC_LK_IDLE : PSC_LK_READ;
                    oe_nxt    = !nack_r && !tx_r[PSC_RESULT_W-1];
                end
                default: begin
                    state_nxt = PSC_LK_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge link_rstn) begin
        if (!link_rstn) begin
            scl_d_r      <= 1'b0;
            sda_d_r      <= 1'b0;
            word_tgl_d_r <= 1'b0;
            word_hold_r  <= '0;
        end else begin
            scl_d_r      <= scl_s;
            sda_d_r      <= sda_s;
            word_tgl_d_r <= word_tgl_s;
            // word is stable for two link cycles before its toggle arrives
            if (word_evt) begin
                word_hold_r <= word_r;
            end
        end
    end

    always_ff @(posedge link_clk or negedge link_rstn) begin
        if (!link_rstn) begin
            state_r      <= PSC_LK_IDLE;
            bit_cnt_r    <= PSC_BIT_ZERO;
            shift_r      <= '0;
            full_r       <= 1'b0;
            sda_drive_en <= 1'b0;
            rw_r         <= 1'b0;
            nack_r       <= 1'b0;
            tx_r         <= '0;
            cmd_byte_r   <= '0;
            cmd_tgl_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            bit_cnt_r    <= bit_cnt_nxt;
            shift_r      <= shift_nxt;
            full_r       <= full_nxt;
            sda_drive_en <= oe_nxt;
            rw_r         <= rw_nxt;
            nack_r       <= nack_nxt;
            tx_r         <= tx_nxt;
            cmd_byte_r   <= cmd_byte_nxt;
            cmd_tgl_r    <= cmd_tgl_nxt;
        end
    end

    // command decode in the reference domain
    assign cmd_evt  = cmd_tgl_s ^ cmd_tgl_d_r;
    assign sel      = cmd_byte_r[PSC_SEL_LSB +: PSC_SEL_W];
    assign is_reset = (cmd_byte_r == PSC_CMD_RESET);
    assign is_adc   = (cmd_byte_r == PSC_CMD_ADC_READ);
    assign is_conversion_flag  = ((cmd_byte_r & PSC_CONVERSION_FLAG_MASK) == PSC_CONVERSION_FLAG_CODE)
                      && (sel <= PSC_RATIO_MAX);
    assign is_cal   = ((cmd_byte_r & PSC_CAL_MASK) == PSC_CAL_CODE);
    assign conversion_flag_start = cmd_evt && is_conversion_flag;

    psc_conversion_flag_timer #(
        .BASE_CYCLES (CONVERSION_FLAG_BASE_CYCLES)
    ) u_conversion_flag (
        .clk       (ref_clk),
        .rst_n     (resetn),
        .start     (conversion_flag_start),
        .abort     (cmd_evt && is_reset),
        .ratio_sel (sel),
        .busy      (conversion_flag),
        .done      (conversion_flag_done)
    );

    genvar g;
    for (g = 0; g < PSC_CAL_SLOTS; g++) begin : g_cal
        if (g < PSC_CAL_WORDS) begin : g_word
            assign cal_slot[g] = cal_hold_r[g*PSC_CAL_WORD_W +: PSC_CAL_WORD_W];
        end else begin : g_none
            assign cal_slot[g] = '0;
        end
    end
    assign cal_word = cal_slot[sel];

    assign sample_pick = type_r ? temperature_sample : pressure_sample;
    // a disturbed conversion still finishes, but delivers a wrong value
    assign result_nxt  = (cmd_evt && is_reset) ? '0 :
                         conversion_flag_done ? (corrupt_r ? ~sample_pick : sample_pick) : result_r;
    assign valid_nxt   = (cmd_evt && is_reset) ? 1'b0 :
                         conversion_flag_done ? 1'b1 :
                         (cmd_evt && (is_adc || is_conversion_flag)) ? 1'b0 : result_valid_r;
    assign corrupt_nxt = ((cmd_evt && is_reset) || conversion_flag_done) ? 1'b0 :
                         (cmd_evt && conversion_flag && (is_adc || is_conversion_flag)) ? 1'b1 :
                         corrupt_r;
    assign word_load   = cmd_evt && (is_reset || is_adc || is_cal);
    assign word_pick   = (is_adc && result_valid_r && !conversion_flag) ? result_r :
                         is_cal ? {cal_word, PSC_PAD_BYTE} : '0;
    assign result_ready = result_valid_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_tgl_d_r    <= 1'b0;
            type_r         <= 1'b0;
            cal_hold_r     <= '0;
            result_r       <= '0;
            result_valid_r <= 1'b0;
            corrupt_r      <= 1'b0;
        end else begin
            cmd_tgl_d_r    <= cmd_tgl_s;
            result_r       <= result_nxt;
            result_valid_r <= valid_nxt;
            corrupt_r      <= corrupt_nxt;
            if (conversion_flag_start) begin
                type_r <= cmd_byte_r[PSC_TYPE_BIT];
            end
            if (cmd_evt && is_reset) begin
                cal_hold_r <= calibration_store;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            word_r     <= '0;
            word_tgl_r <= 1'b0;
        end else if (word_load) begin
            word_r     <= word_pick;
            word_tgl_r <= !word_tgl_r;
        end
    end

    AST_ADDR_ACK: assert property (
        @(posedge link_clk) disable iff (!link_rstn)
        (state_r == PSC_LK_AACK) |-> (addr_hit && sda_drive_en))
        else $error("address ack without matching address");
    AST_STOP_RELEASE: assert property (
        @(posedge link_clk) disable iff (!link_rstn)
        stop_evt |=> (state_r == PSC_LK_IDLE) && !sda_drive_en)
        else $error("stop did not release sda");
    AST_CMD_ACK: assert property (
        @(posedge link_clk) disable iff (!link_rstn)
        (state_r == PSC_LK_WRITE && full_r && scl_fall && !start_evt && !stop_evt)
        |=> sda_drive_en && (cmd_tgl_r != $past(cmd_tgl_r)))
        else $error("command byte not acknowledged");
    AST_READ_MSB: assert property (
        @(posedge link_clk) disable iff (!link_rstn)
        (state_r == PSC_LK_READ && $past(state_r) == PSC_LK_AACK)
        |-> (sda_drive_en == !tx_r[PSC_RESULT_W-1]))
        else $error("first read bit is not the msb");
    AST_ACK_PAUSE: assert property (
        @(posedge link_clk) disable iff (!link_rstn)
        (state_r == PSC_LK_RACK) |-> !sda_drive_en)
        else $error("sda driven during host acknowledge");
    AST_RESET_CMD: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd_evt && is_reset) |=> !conversion_flag && !result_valid_r
        && (cal_hold_r == $past(calibration_store)))
        else $error("reset command did not reload and clear");
    AST_BUSY_NO_RESULT: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        conversion_flag_start |=> (conversion_flag && !result_valid_r) [*2])
        else $error("result valid while converting");
    AST_BUSY_READ_ZERO: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd_evt && is_adc && conversion_flag) |=> (word_r == '0) && corrupt_r)
        else $error("read during conversion did not return zero");
    AST_REPEAT_ZERO: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd_evt && is_adc && !result_valid_r) |=> (word_r == '0))
        else $error("repeated result read not zero");
    AST_CAL_WORD: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd_evt && is_cal) |=> (word_r == {$past(cal_word), PSC_PAD_BYTE}))
        else $error("calibration word not loaded for read");
endmodule
`default_nettype wire

/* psc_sync2.sv */
// two-flop synchroniser for a single level
`default_nettype none
module psc_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the sensor command block
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((ex) !== (got)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import psc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         ref_clk;
    logic         link_clk;
    logic         resetn;
    logic         scl;
    logic         sda_out;
    logic         sda_drive;
    logic         sda_drive_en;
    logic         conversion_flag;
    logic         result_ready;
    logic [111:0] cal;
    logic [23:0]  psamp;
    logic [23:0]  tsamp;
    int           n_errors;
    int           comparisons;
    int           busy_cnt;
    logic         busy_clr;
    wire          sda_wire = (sda_drive_en ? sda_drive : 1'b1) & sda_out;
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    // single driver of the busy counter; the test only requests a clear
    always @(posedge ref_clk) busy_cnt <= busy_clr ? 0 : busy_cnt + int'(conversion_flag === 1'b1);
    // smaller base, yet a read can still land inside the longest conversion
    psc_sensor_cmd #(.CONVERSION_FLAG_BASE_CYCLES(128)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .scl_line(scl),
        .sda_sense(sda_wire), .sda_drive(sda_drive), .sda_drive_en(sda_drive_en),
        .calibration_store(cal), .pressure_sample(psamp), .temperature_sample(tsamp),
        .conversion_flag(conversion_flag), .result_ready(result_ready));
    psc_host_model u_host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_out(sda_out));
    function automatic logic [15:0] cw(input int k);
        return 16'h8421 ^ (16'(k) * 16'h1111);
    endfunction
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        logic a;
        u_host.start();
        u_host.wbyte(8'hEC, a);
        `CHK("wr_addr_ack", 1'b0, a)
        u_host.wbyte(c, a);
        `CHK("cmd_ack", 1'b0, a)
        u_host.stop();
    endtask
    task automatic rd(input int n, output logic [23:0] v);
        logic       a;
        logic [7:0] b;
        v = 24'h000000;
        u_host.start();
        u_host.wbyte(8'hED, a);
        `CHK("rd_addr_ack", 1'b0, a)
        for (int i = 0; i < n; i++) begin
            u_host.rbyte(i == n - 1, b);
            v = {v[15:0], b};
        end
        u_host.stop();
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        while (result_ready !== 1'b1 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k == 20000) begin
            `CHK("ready_wait", 1'b1, 1'b0)
            print_verdict();
        end
    endtask
    initial begin
        logic [23:0] v;
        logic [7:0]  c;
        logic        a;
        int          e;
        int          ks[3] = '{0, 6, 7};
        resetn = 1'b0;
        psamp = 24'h123456;
        tsamp = 24'h654321;
        busy_clr = 1'b1;
        n_errors = 0;
        comparisons = 0;
        for (int k = 0; k < 7; k++) cal[16 * k +: 16] = cw(k);
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (100) @(posedge ref_clk);
        `CHK("flag_idle", 1'b0, conversion_flag)
        `CHK("ready_idle", 1'b0, result_ready)
        u_host.start();
        u_host.wbyte(8'hEE, a);
        `CHK("foreign_ack", 1'b1, a)
        u_host.stop();
        cmd(8'hA2);
        rd(2, v);
        `CHK("cal_unloaded", 24'h000000, v)
        cmd(8'h1E);
        foreach (ks[i]) begin
            cmd(8'hA0 | 8'(ks[i] << 1));
            rd(2, v);
            `CHK("cal_word", ks[i] < 7 ? cw(ks[i]) : 16'h0000, v)
        end
        for (int t = 0; t < 2; t++) begin
            for (int r = 0; r < 6; r++) begin
                c = 8'h40 | 8'(t << 4) | 8'(r << 1);
                psamp <= 24'hC00000 | 24'(c);
                tsamp <= 24'h300000 | 24'(c << 8);
                busy_clr <= 1'b1;
                @(posedge ref_clk);
                busy_clr <= 1'b0;
                cmd(c);
                wait_ready();
                e = 128 << r;
                `CHK("busy_len", 1'b1, busy_cnt >= e && busy_cnt <= e + 1)
                cmd(8'h00);
                rd(3, v);
                `CHK("result", t ? tsamp : psamp, v)
                `CHK("ready_clr", 1'b0, result_ready)
            end
        end
        cmd(8'h40);
        wait_ready();
        cmd(8'h4C);
        cmd(8'h10);
        `CHK("unk_flag", 1'b0, conversion_flag)
        `CHK("unk_ready", 1'b1, result_ready)
        cmd(8'h00);
        rd(3, v);
        `CHK("unk_result", psamp, v)
        cmd(8'h00);
        rd(3, v);
        `CHK("repeat_read", 24'h000000, v)
        cmd(8'h4A);
        cmd(8'h00);
        `CHK("busy_mid", 1'b1, conversion_flag)
        rd(3, v);
        `CHK("read_busy", 24'h000000, v)
        wait_ready();
        cmd(8'h00);
        rd(3, v);
        `CHK("corrupt", ~psamp, v)
        cmd(8'h5A);
        `CHK("busy_on", 1'b1, conversion_flag)
        cmd(8'h1E);
        repeat (8) @(posedge ref_clk);
        `CHK("rst_flag", 1'b0, conversion_flag)
        `CHK("rst_ready", 1'b0, result_ready)
        cmd(8'h00);
        rd(3, v);
        `CHK("rst_result", 24'h000000, v)
        // stray clocks through a frame, then stop and reset frees the bus
        u_host.start();
        u_host.wbyte(8'hEC, a);
        for (int i = 0; i < 9; i++) u_host.bit_io(1'b1, a);
        u_host.stop();
        cmd(8'h1E);
        `CHK("bus_free", 1'b1, sda_wire)
        print_verdict();
    end
endmodule
`default_nettype wire
